// ### src/osd_pin_interface.sv
// Pin-level core of the overlay generator: serial port, sync, PWM and video pins.
//
// Notes on behaviour
// - All logic runs on the pixel clock.
// - Horizontal sync leading edge restarts line timing.
// - Vertical sync leading edge restarts frame timing.
// - Floating select means I2C, else SPI.
// - Serial clock times every serial data bit.
// - Eight 8-bit duties at row 15, columns 19-26.
// - Shared pin carries PWM clock or half-tone.
// - Fast blank asserted while overlay is shown.
// - Separate red, green, blue overlay outputs.
// - Pulse high for duty/256 of period.
// - PWM clock is pixel clock over 8,4,2; rate 3 holds it high.
`timescale 1ns/1ps
module osd_pin_interface #(
    parameter int CHANNELS = 8
) (
    // Pixel clock and reset.
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Video timing inputs.
    input wire logic horizontal_sync_in_i,
    input wire logic vertical_sync_in_i,
    // Serial port.
    input wire logic serial_select_pin_i,
    input wire logic serial_select_float_i,
    input wire logic serial_clock_i,
    input wire logic serial_data_i,
    // Open-drain PWM DAC pins.
    output logic [CHANNELS-1:0] pwm_dac_out_o,
    output logic [CHANNELS-1:0] pwm_dac_oe_o,
    // Overlay video outputs.
    output logic half_tone_out_o,
    output logic fast_blank_out_o,
    output logic red_video_out_o,
    output logic green_video_out_o,
    output logic blue_video_out_o
);
    typedef struct packed {
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic i2c_busy;
        logic addr_phase;
        logic addr_ok;
        osd_pkg::parse_t parse;
        logic [7:0] row_byte;
        logic [5:0] col;
        logic fmt_c;
        logic [CHANNELS-1:0][7:0] duty;
        logic [7:0] ctrl;
        logic [4:0] win_hs;
        logic [4:0] win_he;
        logic [4:0] win_vs;
        logic [4:0] win_ve;
        logic [2:0] div_cnt;
        logic [11:0] hcnt;
        logic [11:0] vcnt;
        logic fb;
        logic [2:0] rgb;
        logic pin;
    } osd_state_t;

    osd_state_t s;
    osd_state_t next_s;

    logic h_fall;
    logic v_fall;
    logic scl_rise;
    logic sda_fall;
    logic sda_rise;
    logic spi_sel;
    logic byte_stb;
    logic [7:0] byte_val;
    logic wr_en;
    logic reg_wr;
    logic in_win;
    logic tick;
    logic pwm_clk_lvl;
    logic [2:0] rate_m;
    logic [CHANNELS-1:0] pwm_lvl;

    // Mask of divider bits for one PWM clock period.
    function automatic logic [2:0] rate_mask(input logic [1:0] rate);
        case (rate)
            2'h0: rate_mask = 3'h7;
            2'h1: rate_mask = 3'h3;
            2'h2: rate_mask = 3'h1;
            default: rate_mask = 3'h0;
        endcase
    endfunction

    sync_edge u_hsync (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .sig_i(horizontal_sync_in_i),
        .fall_o(h_fall),
        .rise_o()
    );

    sync_edge u_vsync (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .sig_i(vertical_sync_in_i),
        .fall_o(v_fall),
        .rise_o()
    );

    sync_edge u_sck (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .sig_i(serial_clock_i),
        .fall_o(),
        .rise_o(scl_rise)
    );

    sync_edge u_sda (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .sig_i(serial_data_i),
        .fall_o(sda_fall),
        .rise_o(sda_rise)
    );

    assign spi_sel = ~serial_select_float_i & ~serial_select_pin_i;
    assign rate_m = rate_mask(s.ctrl[osd_pkg::CTRL_RATE_LSB +: 2]);
    assign tick = (s.div_cnt & rate_m) == rate_m;
    assign pwm_clk_lvl = (rate_m == 3'h0) || ((s.div_cnt & rate_m & ~(rate_m >> 1)) != 3'h0);
    assign in_win = s.ctrl[osd_pkg::CTRL_EN_BIT]
        && s.hcnt[11:3] >= {4'h0, s.win_hs} && s.hcnt[11:3] < {4'h0, s.win_he}
        && s.vcnt[11:2] >= {5'h00, s.win_vs} && s.vcnt[11:2] < {5'h00, s.win_ve};

    always_comb begin
        next_s = s;
        byte_stb = 1'b0;
        wr_en = 1'b0;
        byte_val = {s.shreg[6:0], serial_data_i};
        // Serial bit and byte framing.
        if (serial_select_float_i) begin
            if (sda_fall && serial_clock_i) begin
                next_s.i2c_busy = 1'b1;
                next_s.addr_phase = 1'b1;
                next_s.addr_ok = 1'b0;
                next_s.bit_cnt = 4'h0;
                next_s.parse = osd_pkg::P_ROW;
                next_s.fmt_c = 1'b0;
            end else if (sda_rise && serial_clock_i) begin
                next_s.i2c_busy = 1'b0;
                next_s.parse = osd_pkg::P_ROW;
                next_s.fmt_c = 1'b0;
            end else if (scl_rise && s.i2c_busy) begin
                // The acknowledge slot is counted but carries no data bit.
                if (s.bit_cnt == osd_pkg::ACK_SLOT) begin
                    next_s.bit_cnt = 4'h0;
                end else begin
                    next_s.shreg = byte_val;
                    next_s.bit_cnt = s.bit_cnt + 4'h1;
                    if (s.bit_cnt == osd_pkg::BYTE_LAST) begin
                        if (s.addr_phase) begin
                            next_s.addr_phase = 1'b0;
                            next_s.addr_ok = byte_val == osd_pkg::I2C_ADDR;
                        end else begin
                            byte_stb = s.addr_ok;
                        end
                    end
                end
            end
        end else if (spi_sel) begin
            if (scl_rise) begin
                next_s.shreg = byte_val;
                byte_stb = s.bit_cnt == osd_pkg::BYTE_LAST;
                next_s.bit_cnt = byte_stb ? 4'h0 : s.bit_cnt + 4'h1;
            end
        end else begin
            // Select high ends the SPI packet and drops any partial byte.
            next_s.bit_cnt = 4'h0;
            next_s.parse = osd_pkg::P_ROW;
            next_s.fmt_c = 1'b0;
            next_s.i2c_busy = 1'b0;
        end
        // Packet parser: row, column, data with sticky format c.
        if (byte_stb) begin
            case (s.parse)
                osd_pkg::P_ROW: begin
                    if (byte_val[osd_pkg::ROW_BIT]) begin
                        next_s.row_byte = byte_val;
                        next_s.parse = osd_pkg::P_COL;
                    end
                end
                osd_pkg::P_COL: begin
                    if (byte_val[osd_pkg::ROW_BIT]) begin
                        next_s.row_byte = byte_val;
                    end else begin
                        next_s.col = byte_val[5:0];
                        next_s.fmt_c = byte_val[osd_pkg::FMT_C_BIT];
                        next_s.parse = osd_pkg::P_DATA;
                    end
                end
                osd_pkg::P_DATA: begin
                    wr_en = 1'b1;
                    if (s.fmt_c) begin
                        next_s.col = s.col + 6'h01;
                    end else begin
                        next_s.parse = osd_pkg::P_COL;
                    end
                end
                default: begin
                    next_s.parse = osd_pkg::P_ROW;
                end
            endcase
        end
        // Only display address bytes of the PWM row land here.
        reg_wr = wr_en && s.row_byte[7:5] == osd_pkg::ROW_DISP_ADDR
            && s.row_byte[3:0] == osd_pkg::DUTY_ROW;
        if (reg_wr) begin
            for (int k = 0; k < CHANNELS; k++) begin
                if (s.col == osd_pkg::COL_DUTY0 + 6'(k)) begin
                    next_s.duty[k] = byte_val;
                end
            end
            case (s.col)
                osd_pkg::COL_CTRL: next_s.ctrl = byte_val;
                osd_pkg::COL_WIN_HS: next_s.win_hs = byte_val[4:0];
                osd_pkg::COL_WIN_HE: next_s.win_he = byte_val[4:0];
                osd_pkg::COL_WIN_VS: next_s.win_vs = byte_val[4:0];
                osd_pkg::COL_WIN_VE: next_s.win_ve = byte_val[4:0];
                default: next_s.ctrl = s.ctrl;
            endcase
        end
        // Video timing and the overlay, free running from sync edges.
        next_s.div_cnt = s.div_cnt + 3'h1;
        next_s.hcnt = h_fall ? 12'h000 : s.hcnt + 12'h001;
        if (v_fall) begin
            next_s.vcnt = 12'h000;
        end else if (h_fall) begin
            next_s.vcnt = s.vcnt + 12'h001;
        end
        next_s.fb = in_win;
        next_s.rgb = in_win ? s.ctrl[osd_pkg::CTRL_COLOR_LSB +: 3] : 3'h0;
        if (s.ctrl[osd_pkg::CTRL_SEL_BIT]) begin
            next_s.pin = pwm_clk_lvl;
        end else begin
            next_s.pin = in_win & s.ctrl[osd_pkg::CTRL_HT_BIT];
        end
    end

    // Single clock domain: the pixel clock drives every flip-flop.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= '0;
            s.ctrl <= osd_pkg::CTRL_RST;
            s.win_hs <= osd_pkg::WIN_RST;
            s.win_he <= osd_pkg::WIN_RST;
            s.win_vs <= osd_pkg::WIN_RST;
            s.win_ve <= osd_pkg::WIN_RST;
        end else begin
            s <= next_s;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_pwm
            pwm_channel #(
                .W(8)
            ) u_pwm (
                .ref_clk_i(ref_clk_i),
                .nrst_i(nrst_i),
                .tick_i(tick),
                .duty_i(s.duty[g]),
                .pwm_o(pwm_lvl[g])
            );
        end
    endgenerate

    // Open drain: the pin is pulled low while the channel is inactive.
    assign pwm_dac_out_o = '0;
    assign pwm_dac_oe_o = ~pwm_lvl;
    assign half_tone_out_o = s.pin;
    assign fast_blank_out_o = s.fb;
    assign red_video_out_o = s.rgb[2];
    assign green_video_out_o = s.rgb[1];
    assign blue_video_out_o = s.rgb[0];

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_hsync_restart: assert property (
        h_fall |=> s.hcnt == 12'h000 ##1 s.hcnt == 12'h001 || $past(h_fall))
        else $error("line counter not restarted by hsync");
    a_vsync_restart: assert property (
        v_fall |=> s.vcnt == 12'h000)
        else $error("frame counter not restarted by vsync");
    a_spi_idle_drop: assert property (
        !serial_select_float_i && serial_select_pin_i |=> s.bit_cnt == 4'h0)
        else $error("bit count kept with select high");
    a_duty_write: assert property (
        reg_wr && s.col == osd_pkg::COL_DUTY0 |=> s.duty[0] == $past(byte_val))
        else $error("duty register not written");
    a_pin_route: assert property (
        s.ctrl[osd_pkg::CTRL_SEL_BIT] && $stable(s.ctrl) |=> half_tone_out_o == $past(pwm_clk_lvl))
        else $error("shared pin not carrying pwm clock");
    a_blank_follows: assert property (
        in_win && $stable(s.ctrl) |=> fast_blank_out_o)
        else $error("fast blank missing over window");
    a_rgb_colour: assert property (
        fast_blank_out_o |-> s.rgb == $past(s.ctrl[osd_pkg::CTRL_COLOR_LSB +: 3]))
        else $error("overlay colour wrong");
    a_rgb_idle: assert property (
        !fast_blank_out_o |-> s.rgb == 3'h0)
        else $error("colour active without blanking");
    a_addr_match: assert property (
        byte_stb && serial_select_float_i |-> s.addr_ok && s.i2c_busy && !s.addr_phase)
        else $error("i2c byte accepted without address");

    c_i2c_addr: cover property (s.addr_ok ##1 byte_stb);
    c_fmt_c_write: cover property (reg_wr && s.fmt_c ##1 reg_wr);
    c_overlay_on: cover property (fast_blank_out_o && red_video_out_o);
endmodule

// ### include/osd_pkg.sv
// Shared constants and types of the overlay pin interface.
package osd_pkg;
    // Register map reached through the serial packets.
    localparam logic [3:0] DUTY_ROW = 4'hF;
    localparam logic [5:0] COL_DUTY0 = 6'h13;
    localparam logic [5:0] COL_CTRL = 6'h1B;
    localparam logic [5:0] COL_WIN_HS = 6'h1C;
    localparam logic [5:0] COL_WIN_HE = 6'h1D;
    localparam logic [5:0] COL_WIN_VS = 6'h1E;
    localparam logic [5:0] COL_WIN_VE = 6'h1F;
    // Row byte: marker bit and display address code; column byte: format c bit.
    localparam logic [2:0] ROW_DISP_ADDR = 3'h4;
    localparam int ROW_BIT = 7;
    localparam int FMT_C_BIT = 6;
    // Control register fields.
    localparam int CTRL_RATE_LSB = 0;
    localparam int CTRL_SEL_BIT = 2;
    localparam int CTRL_EN_BIT = 3;
    localparam int CTRL_HT_BIT = 4;
    localparam int CTRL_COLOR_LSB = 5;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [4:0] WIN_RST = 5'h00;
    // Serial framing.
    localparam logic [7:0] I2C_ADDR = 8'h7A;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // PWM period is 256 steps.
    localparam logic [7:0] PWM_LAST = 8'hFF;
    // Packet parser states.
    typedef enum logic [1:0] {
        P_ROW,
        P_COL,
        P_DATA
    } parse_t;
endpackage

// ### src/sync_edge.sv
// Edge detector for a pin that idles high through its pull-up.
`timescale 1ns/1ps
module sync_edge (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Sampled pin and its edges.
    input wire logic sig_i,
    output logic fall_o,
    output logic rise_o
);
    typedef struct packed {
        logic prev;
    } edge_state_t;

    edge_state_t s;
    edge_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.prev = sig_i;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= '{prev: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    assign fall_o = s.prev & ~sig_i;
    assign rise_o = ~s.prev & sig_i;
endmodule

// ### src/pwm_channel.sv
// One 8-bit PWM DAC channel stepped by a shared rate enable.
`timescale 1ns/1ps
module pwm_channel #(
    parameter int W = 8
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Rate enable and duty value.
    input wire logic tick_i,
    input wire logic [W-1:0] duty_i,
    // Active level of the channel.
    output logic pwm_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] duty;
        logic out;
    } pwm_state_t;

    pwm_state_t s;
    pwm_state_t next_s;

    always_comb begin
        next_s = s;
        if (tick_i) begin
            next_s.cnt = s.cnt + 1'b1;
            // Loading only on wrap keeps every pulse whole.
            if (&s.cnt) begin
                next_s.duty = duty_i;
            end
        end
        next_s.out = next_s.cnt < next_s.duty;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pwm_o = s.out;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_duty_period_hold: assert property (
        !(tick_i && &s.cnt) |=> s.duty == $past(s.duty))
        else $error("duty changed inside a period");
    a_pwm_level_duty: assert property (
        pwm_o == (s.cnt < s.duty))
        else $error("pwm level does not follow duty");
    c_pwm_high: cover property (pwm_o && s.duty != 0);
endmodule

// ### tb/mcu_serial_model.sv
// Behavioural microcontroller that writes packets over the SPI or I2C serial port.
`timescale 1ns/1ps
module mcu_serial_model (
    // Pixel clock that paces the bit timing.
    input wire logic ref_clk_i,
    // Serial port pins.
    output logic select_o,
    output logic float_o,
    output logic sck_o,
    output logic sda_o
);
    // Lines with pull-ups idle high.
    initial begin
        select_o = 1'b1;
        float_o = 1'b0;
        sck_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // Each level stands three pixel clocks, more than the one the port needs.
    task automatic bit_out(input logic b);
        sck_o <= 1'b0;
        wt(3);
        sda_o <= b;
        wt(3);
        sck_o <= 1'b1;
        wt(3);
    endtask
    // The acknowledge slot is left to the pull-up, since the device never drives it.
    task automatic send(input bit i2c, input logic [7:0] addr, input logic [7:0] q[$]);
        @(posedge ref_clk_i);
        float_o <= i2c;
        wt(3);
        if (i2c) begin
            sda_o <= 1'b0;
            wt(3);
            for (int i = 7; i >= 0; i--) bit_out(addr[i]);
            bit_out(1'b1);
        end else begin
            select_o <= 1'b0;
            wt(3);
        end
        foreach (q[k]) begin
            for (int i = 7; i >= 0; i--) bit_out(q[k][i]);
            if (i2c) bit_out(1'b1);
        end
        if (i2c) begin
            sck_o <= 1'b0;
            wt(3);
            sda_o <= 1'b0;
            wt(3);
            sck_o <= 1'b1;
            wt(3);
        end else begin
            select_o <= 1'b1;
        end
        sda_o <= 1'b1;
        wt(3);
    endtask
    // SPI packet abandoned after a few bits by raising select early.
    task automatic cut(input int nbits);
        @(posedge ref_clk_i);
        float_o <= 1'b0;
        wt(3);
        select_o <= 1'b0;
        wt(3);
        repeat (nbits) bit_out(1'b1);
        select_o <= 1'b1;
        sda_o <= 1'b1;
        wt(3);
    endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the overlay pin interface.
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] ROWB = {4'h8, osd_pkg::DUTY_ROW};
    logic clk = 1'b0;
    logic nrst;
    logic hs;
    logic vs;
    logic sel;
    logic flt;
    logic sck;
    logic sda;
    logic [7:0] pwm_out;
    logic [7:0] pwm_oe;
    logic ht;
    logic fb;
    logic r;
    logic g;
    logic b;
    int err_total = 0;
    int compares = 0;
    logic [7:0] duty [8];
    logic [7:0] junk [8];
    int hi [8];
    int n;
    int bad;
    int rises;
    logic prev;

    always #2.5 clk = ~clk;

    osd_pin_interface osd_pin_interface_i (.ref_clk_i(clk), .nrst_i(nrst),
        .horizontal_sync_in_i(hs), .vertical_sync_in_i(vs), .serial_select_pin_i(sel),
        .serial_select_float_i(flt), .serial_clock_i(sck), .serial_data_i(sda),
        .pwm_dac_out_o(pwm_out), .pwm_dac_oe_o(pwm_oe), .half_tone_out_o(ht),
        .fast_blank_out_o(fb), .red_video_out_o(r), .green_video_out_o(g),
        .blue_video_out_o(b));
    mcu_serial_model mcu_serial_model_i (.ref_clk_i(clk), .select_o(sel), .float_o(flt),
        .sck_o(sck), .sda_o(sda));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // Clocks a channel stays active in one period at rate select rt.
    function automatic int active_clocks(input logic [7:0] d, input int rt);
        return int'(d) * (8 >> rt);
    endfunction

    task automatic summarize();
        $display("counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input bit i2c, input logic [5:0] col, input logic [7:0] d);
        logic [7:0] q[$];
        q = '{ROWB, {2'b00, col}, d};
        mcu_serial_model_i.send(i2c, osd_pkg::I2C_ADDR, q);
    endtask

    // Format c burst: the column steps on by itself through all eight duties.
    task automatic burst(input bit i2c, input logic [7:0] addr, input logic [7:0] d [8]);
        logic [7:0] q[$];
        q = '{ROWB, 8'h40 | {2'b00, osd_pkg::COL_DUTY0}};
        for (int i = 0; i < 8; i++) q.push_back(d[i]);
        mcu_serial_model_i.send(i2c, addr, q);
    endtask

    // Active means the open-drain pin is released, so the enable is low.
    task automatic measure(input int len);
        bad = 0;
        for (int i = 0; i < 8; i++) hi[i] = 0;
        repeat (len) begin
            @(negedge clk);
            for (int i = 0; i < 8; i++) hi[i] += (pwm_oe[i] === 1'b0);
            bad += (pwm_out !== 8'h00);
        end
    endtask

    // One 64-clock line; the pixel clock is an exact multiple of the line rate.
    task automatic line();
        n = 0;
        bad = 0;
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            if (i == 0) hs <= 1'b0;
            if (i == 4) hs <= 1'b1;
            @(negedge clk);
            n += (fb === 1'b1);
            bad += ({r, g, b} !== {3{fb}}) || (ht !== fb);
        end
    endtask

    initial begin
        nrst = 1'b0;
        hs = 1'b1;
        vs = 1'b1;
        void'($urandom(81395));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk(pwm_oe, 8'hFF, "oe after reset");
        chk({ht, fb, r, g, b, pwm_out}, 13'h0000, "outputs after reset");
        $display("test reset done");

        for (int i = 0; i < 8; i++) duty[i] = 8'($urandom);
        duty[0] = 8'h00;
        duty[7] = 8'hFF;
        burst(1'b0, osd_pkg::I2C_ADDR, duty);
        for (int rt = 0; rt < 4; rt++) begin
            wr(1'b0, osd_pkg::COL_CTRL, 8'h04 | 8'(rt));
            @(negedge clk);
            prev = ht;
            rises = 0;
            n = 0;
            repeat (64) begin
                @(negedge clk);
                n += (ht === 1'b1);
                rises += (ht === 1'b1 && prev === 1'b0);
                prev = ht;
            end
            chk(rises, (rt == 3) ? 0 : (8 << rt), "pwm clock edges");
            chk(n, (rt == 3) ? 64 : 32, "pwm clock high time");
            repeat (256 << (3 - rt)) @(negedge clk);
            measure(256 << (3 - rt));
            chk(bad, 0, "open drain value");
            for (int i = 0; i < 8; i++) chk(hi[i], active_clocks(duty[i], rt), "duty");
        end
        $display("test spi duty and rates done");

        for (int i = 0; i < 8; i++) duty[i] = 8'($urandom);
        for (int i = 0; i < 8; i++) junk[i] = ~duty[i];
        burst(1'b1, osd_pkg::I2C_ADDR, duty);
        burst(1'b1, 8'h7C, junk);
        repeat (256) @(negedge clk);
        measure(256);
        for (int i = 0; i < 8; i++) chk(hi[i], active_clocks(duty[i], 3), "i2c duty");
        $display("test i2c done");

        // A cut packet must leave no stray bits in front of the next one.
        duty[0] = ~duty[0];
        mcu_serial_model_i.cut(1 + int'($urandom % 7));
        wr(1'b0, osd_pkg::COL_DUTY0, duty[0]);
        repeat (256) @(negedge clk);
        measure(256);
        chk(hi[0], active_clocks(duty[0], 3), "duty after cut packet");
        $display("test cut packet done");

        wr(1'b0, osd_pkg::COL_CTRL, 8'hF8);
        wr(1'b0, osd_pkg::COL_WIN_HS, 8'h01);
        wr(1'b0, osd_pkg::COL_WIN_HE, 8'h03);
        wr(1'b0, osd_pkg::COL_WIN_VS, 8'h00);
        wr(1'b0, osd_pkg::COL_WIN_VE, 8'h02);
        for (int f = 0; f < 3; f++) begin
            if (f == 2) wr(1'b0, osd_pkg::COL_CTRL, 8'hF0);
            @(posedge clk);
            vs <= 1'b0;
            repeat (4) @(posedge clk);
            vs <= 1'b1;
            for (int ln = 0; ln < 11; ln++) begin
                line();
                chk(bad, 0, "colour or half tone vs blank");
                if (ln == 2) chk(n, (f < 2) ? 16 : 0, "blank width in window");
                if (ln == 10) chk(n, 0, "blank below window");
            end
        end
        $display("test video done");
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end
endmodule
